// ===== logic/dcb_top.sv
/*
  Command decoder and per-bank state tracker for a four-bank memory device.
  Assumes all memory pins come from another clock domain; they are
  synchronised here; all but termination and self refresh exit are sampled on rising edges of the recovered link clock.
*/
// What this block does
// RQ1: decode from select, strobes and two clock-enable samples
// RQ2: strobe levels encode each command; select high deselects
// RQ3: A10 picks auto precharge or all-bank precharge
// RQ4: bank address selects bank or mode register
// RQ5: self refresh enters on refresh, leaves on enable
// RQ6: four-beat bursts run out unless a later read or precharge, or a write on a write burst, cuts in
// RQ7: controller bounds power-down by refresh interval
// RQ8: termination ignored; unavailable during self refresh
// RQ9: bank checks only with enable high twice
// RQ10: refresh and mode load need all banks idle
// RQ11: active bank takes read, write or precharge
// RQ12: reading bank takes read, precharge; write after
// RQ13: writing bank takes read, write or precharge
// RQ14: precharging lasts the precharge time, then idle
// RQ15: activating lasts the row delay, then active
// RQ16: auto precharge access busy until precharge done
// RQ17: refresh busy for refresh time, then idle
// RQ18: precharge all busy for precharge time
// RQ19: mode load busy for mode delay time
// RQ20: non-interruptible bank only sees allowed commands
// RQ21: every bank of group precharge must permit it
// RQ22: unlisted state and command pairs are illegal
// RQ23: flag and ignore illegal commands, states unchanged
`timescale 1ns/1ns
`default_nettype none

module dcb_top
  import dcb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // memory link pins
  input wire logic mem_ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dcb_pkg::BA_W-1:0] ba,
  input wire logic [dcb_pkg::ADDR_W-1:0] addr,
  input wire logic odt,
  // status
  output logic [3:0] cmd_code,
  output logic cmd_valid,
  output logic cmd_illegal,
  output logic [dcb_pkg::BA_W-1:0] cmd_bank,
  output logic [11:0] bank_states,
  output logic [2:0] dev_state,
  output logic odt_active,
  output logic [dcb_pkg::BA_W-1:0] mode_reg_sel,
  output logic mode_load
);

  import dcb_pkg::*;

  // ==========================================================
  // state
  localparam int unsigned PIN_W = 7 + BA_W + 1;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic ck_prev;
    logic cke_prev;
    dcb_bank_e [NUM_BANKS-1:0] bank;
    logic [NUM_BANKS-1:0][CNT_W-1:0] bcnt;
    logic [NUM_BANKS-1:0] bap;
    dcb_dev_e dev;
    logic [CNT_W-1:0] dcnt;
    logic [3:0] code;
    logic valid;
    logic illegal;
    logic [BA_W-1:0] bank_o;
    logic odt_o;
    logic [BA_W-1:0] mrs;
    logic mload;
  } dcb_state_s;

  dcb_state_s st_q;
  dcb_state_s st_d;

  // ==========================================================
  // decode and track
  logic ck_s;
  logic cke_s;
  logic cs_s;
  logic [2:0] enc_s;
  logic [BA_W-1:0] ba_s;
  logic a10_s;
  logic odt_s;
  logic rise;
  dcb_cmd_e cmd;
  logic all_idle;
  logic ok;
  int unsigned b;

  assign {ck_s, cke_s, cs_s, enc_s, ba_s, a10_s, odt_s} = st_q.s2;
  assign rise = ck_s && !st_q.ck_prev;

  always_comb
  begin
    st_d = st_q;
    cmd = CMD_NOP;
    ok = 1'b1;
    b = 0;
    all_idle = 1'b1;
    // second stage reads only first stage; logic reads only second
    st_d.s1 = {mem_ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr[AP_BIT], odt};
    st_d.s2 = st_q.s1;
    st_d.ck_prev = ck_s;
    st_d.valid = 1'b0;
    st_d.illegal = 1'b0;
    st_d.mload = 1'b0;

    // timers advance on system clock, since link clock may stop
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      if (st_q.bcnt[i] != '0)
      begin
        st_d.bcnt[i] = st_q.bcnt[i] - CNT_W'(1);
      end
      else
      begin
        case (st_q.bank[i])
          BK_ACTIVATING: st_d.bank[i] = BK_ACTIVE; // [RQ15]
          BK_PRECHARGING: st_d.bank[i] = BK_IDLE; // [RQ14]
          BK_READ, BK_WRITE: st_d.bank[i] = BK_ACTIVE; // [RQ6]
          BK_AUTO_PRE:
          begin
            // burst done, now the internal precharge
            if (st_q.bap[i])
            begin
              st_d.bap[i] = 1'b0;
              st_d.bcnt[i] = RP_CYC; // [RQ16]
            end
            else
            begin
              st_d.bank[i] = BK_IDLE; // [RQ16]
            end
          end
          default: st_d.bank[i] = st_q.bank[i];
        endcase
      end
      if (st_q.bank[i] != BK_IDLE)
      begin
        all_idle = 1'b0;
      end
    end

    if (st_q.dcnt != '0)
    begin
      st_d.dcnt = st_q.dcnt - CNT_W'(1);
    end
    else if (st_q.dev == DV_REFRESH || st_q.dev == DV_MODE
             || st_q.dev == DV_EXIT_WAIT)
    begin
      st_d.dev = DV_NORMAL; // [RQ17] [RQ19]
    end
    else if (st_q.dev == DV_PRE_ALL)
    begin
      st_d.dev = DV_NORMAL; // [RQ18]
    end

    // self refresh exit does not wait for a link clock edge
    if (st_q.dev == DV_SELF_REF && cke_s && (cs_s || enc_s == ENC_NOP))
    begin
      st_d.dev = DV_EXIT_WAIT; // [RQ5]
      st_d.dcnt = XSNR_CYC;
      st_d.cke_prev = 1'b1;
    end
    else if (rise)
    begin
      st_d.cke_prev = cke_s;
      // decode from both enable samples and pin levels
      if (!st_q.cke_prev)
      begin
        cmd = cke_s ? CMD_EXIT : CMD_NOP; // [RQ1]
      end
      else if (cs_s)
      begin
        cmd = cke_s ? CMD_DESEL : CMD_PDN; // [RQ2]
      end
      else
      begin
        case (enc_s) // [RQ2]
          ENC_NOP: cmd = cke_s ? CMD_NOP : CMD_PDN;
          ENC_ACT: cmd = CMD_ACT;
          ENC_RD: cmd = a10_s ? CMD_RDA : CMD_RD; // [RQ3]
          ENC_WR: cmd = a10_s ? CMD_WRA : CMD_WR; // [RQ3]
          ENC_PRE: cmd = a10_s ? CMD_PREA : CMD_PRE; // [RQ3]
          ENC_REF: cmd = cke_s ? CMD_REF : CMD_SREF; // [RQ5]
          ENC_LMR: cmd = CMD_LMR;
          default: cmd = CMD_RSVD;
        endcase
        if (!cke_s && enc_s != ENC_REF && enc_s != ENC_NOP)
        begin
          cmd = CMD_RSVD;
        end
      end

      b = int'(ba_s) % NUM_BANKS; // [RQ4]
      case (cmd)
        CMD_DESEL, CMD_NOP: ok = 1'b1;
        CMD_EXIT: ok = (st_q.dev == DV_POWER_DN);
        CMD_PDN: ok = (st_q.dev == DV_NORMAL);
        CMD_ACT: ok = (st_q.dev == DV_NORMAL) && st_q.bank[b] == BK_IDLE;
        CMD_RD, CMD_RDA: ok = (st_q.dev == DV_NORMAL)
          && (st_q.bank[b] == BK_ACTIVE || st_q.bank[b] == BK_READ
          || st_q.bank[b] == BK_WRITE); // [RQ11] [RQ12] [RQ13]
        CMD_WR, CMD_WRA: ok = (st_q.dev == DV_NORMAL)
          && (st_q.bank[b] == BK_ACTIVE
          || st_q.bank[b] == BK_WRITE); // [RQ12] [RQ13]
        CMD_PRE: ok = (st_q.dev == DV_NORMAL)
          && (st_q.bank[b] == BK_ACTIVE || st_q.bank[b] == BK_READ
          || st_q.bank[b] == BK_WRITE || st_q.bank[b] == BK_IDLE);
        CMD_PREA:
        begin
          ok = (st_q.dev == DV_NORMAL);
          for (int i = 0; i < NUM_BANKS; i++)
          begin
            if (st_q.bank[i] inside {BK_ACTIVATING, BK_AUTO_PRE,
                                     BK_PRECHARGING})
            begin
              ok = 1'b0; // [RQ21]
            end
          end
        end
        CMD_REF, CMD_SREF, CMD_LMR:
          ok = (st_q.dev == DV_NORMAL) && all_idle; // [RQ10]
        default: ok = 1'b0; // [RQ22]
      endcase

      st_d.valid = (cmd != CMD_DESEL) && (cmd != CMD_NOP);
      st_d.code = cmd;
      st_d.bank_o = ba_s;
      // illegal commands are flagged and leave bank and device states alone
      st_d.illegal = !ok; // [RQ23]
      if (ok)
      begin
        case (cmd)
          CMD_ACT:
          begin
            st_d.bank[b] = BK_ACTIVATING; // [RQ15]
            st_d.bcnt[b] = RCD_CYC;
          end
          CMD_RD, CMD_WR:
          begin
            st_d.bank[b] = (cmd == CMD_RD) ? BK_READ : BK_WRITE;
            st_d.bcnt[b] = BURST_CYC; // [RQ6]
          end
          CMD_RDA, CMD_WRA:
          begin
            st_d.bank[b] = BK_AUTO_PRE; // [RQ16]
            st_d.bap[b] = 1'b1;
            st_d.bcnt[b] = BURST_CYC;
          end
          CMD_PRE:
          begin
            st_d.bank[b] = BK_PRECHARGING; // [RQ14]
            st_d.bcnt[b] = RP_CYC;
          end
          CMD_PREA:
          begin
            for (int i = 0; i < NUM_BANKS; i++)
            begin
              st_d.bank[i] = BK_PRECHARGING;
              st_d.bcnt[i] = RP_CYC;
            end
            st_d.dev = DV_PRE_ALL; // [RQ18]
            st_d.dcnt = RP_CYC;
          end
          CMD_REF:
          begin
            st_d.dev = DV_REFRESH; // [RQ17]
            st_d.dcnt = RFC_CYC;
          end
          CMD_SREF: st_d.dev = DV_SELF_REF; // [RQ5]
          CMD_PDN: st_d.dev = DV_POWER_DN;
          CMD_EXIT: st_d.dev = DV_NORMAL;
          CMD_LMR:
          begin
            st_d.dev = DV_MODE; // [RQ19]
            st_d.dcnt = MRD_CYC;
            st_d.mrs = ba_s; // [RQ4]
            st_d.mload = 1'b1;
          end
          default: st_d.dev = st_q.dev;
        endcase
      end
    end
    // termination never decoded; follows next state so no overlap with self refresh
    st_d.odt_o = odt_s && (st_d.dev != DV_SELF_REF); // [RQ8]
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign cmd_code = st_q.code;
  assign cmd_valid = st_q.valid;
  assign cmd_illegal = st_q.illegal;
  assign cmd_bank = st_q.bank_o;
  assign bank_states = {st_q.bank[3], st_q.bank[2], st_q.bank[1], st_q.bank[0]};
  assign dev_state = st_q.dev;
  assign odt_active = st_q.odt_o;
  assign mode_reg_sel = st_q.mrs;
  assign mode_load = st_q.mload;

endmodule // dcb_top
`default_nettype wire

// ===== logic/dcb_pkg.sv
/*
  Package for the command decoder and bank state tracker: pin encodings,
  bank states, commands and timing counts.
  Assumes a 20 MHz system clock that oversamples the memory link clock.
*/
`default_nettype none

package dcb_pkg;

  // =========================================================
  // sizes
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BA_W = 3;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned CNT_W = 8;

  // =========================================================
  // timing, in ns, and derived system clock counts
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_RCD_NS = 15;
  localparam int unsigned T_RP_NS = 15;
  localparam int unsigned T_RFC_NS = 105;
  localparam int unsigned T_MRD_NS = 10;
  localparam int unsigned T_BURST_NS = 800;
  localparam int unsigned T_XSNR_NS = 200;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] RCD_CYC = cyc(T_RCD_NS);
  localparam logic [CNT_W-1:0] RP_CYC = cyc(T_RP_NS);
  localparam logic [CNT_W-1:0] RFC_CYC = cyc(T_RFC_NS);
  localparam logic [CNT_W-1:0] MRD_CYC = cyc(T_MRD_NS);
  localparam logic [CNT_W-1:0] BURST_CYC = cyc(T_BURST_NS);
  localparam logic [CNT_W-1:0] XSNR_CYC = cyc(T_XSNR_NS);

  // =========================================================
  // command pin codes {ras_n, cas_n, we_n}
  localparam logic [2:0] ENC_ACT = 3'h3;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_WR = 3'h4;
  localparam logic [2:0] ENC_PRE = 3'h2;
  localparam logic [2:0] ENC_REF = 3'h1;
  localparam logic [2:0] ENC_LMR = 3'h0;
  localparam logic [2:0] ENC_NOP = 3'h7;

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
    CMD_PRE, CMD_PREA, CMD_REF, CMD_SREF, CMD_LMR, CMD_PDN, CMD_EXIT,
    CMD_RSVD
  } dcb_cmd_e;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_AUTO_PRE,
    BK_PRECHARGING
  } dcb_bank_e;

  typedef enum logic [2:0] {
    DV_NORMAL, DV_REFRESH, DV_MODE, DV_PRE_ALL, DV_SELF_REF, DV_POWER_DN,
    DV_EXIT_WAIT
  } dcb_dev_e;

endpackage
`default_nettype wire

// ===== testbench/dcb_chk.sv
/* assertions on the tracker status outputs
   assumes the dcb_top port list; bound below */
`timescale 1ns/1ns
`default_nettype none
module dcb_chk
  import dcb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // status
  input wire logic [3:0] cmd_code,
  input wire logic cmd_valid,
  input wire logic cmd_illegal,
  input wire logic [dcb_pkg::BA_W-1:0] cmd_bank,
  input wire logic [11:0] bank_states,
  input wire logic [2:0] dev_state,
  input wire logic odt_active,
  input wire logic [dcb_pkg::BA_W-1:0] mode_reg_sel,
  input wire logic mode_load
);
  // =========================================================
  // helpers
  logic [2:0] cur_bk;
  // trusts the controller to leave the bank alone meanwhile
  assign cur_bk = bank_states[3*cmd_bank[1:0] +: 3];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // =========================================================
  // properties
  a_refused_seen: assert property (cmd_illegal |-> cmd_valid)
    else $error("refused command not reported");
  a_nop_quiet: assert property (cmd_valid |-> !(cmd_code inside {CMD_NOP, CMD_DESEL}))
    else $error("nop reported as command");
  a_refused_noload: assert property (cmd_illegal |-> !mode_load)
    else $error("refused command loaded mode");
  a_mode_sel: assert property (mode_load |-> cmd_code == CMD_LMR && mode_reg_sel == cmd_bank)
    else $error("mode register select wrong");
  a_mode_ends: assert property (mode_load |-> dev_state == DV_MODE ##[1:4] dev_state == DV_NORMAL)
    else $error("mode load busy wrong");
  a_ref_ends: assert property ($rose(dev_state == DV_REFRESH) |-> ##[1:6] dev_state == DV_NORMAL)
    else $error("refresh busy wrong");
  a_act_ends: assert property (cmd_valid && !cmd_illegal && cmd_code == CMD_ACT |->
    cur_bk == BK_ACTIVATING ##[1:3] cur_bk == BK_ACTIVE)
    else $error("activate timing wrong");
  a_pre_ends: assert property (cmd_valid && !cmd_illegal && cmd_code == CMD_PRE |->
    ##[0:3] cur_bk == BK_IDLE)
    else $error("precharge timing wrong");
  a_prea_ends: assert property (cmd_valid && !cmd_illegal && cmd_code == CMD_PREA |->
    ##[1:4] bank_states == 12'h000 && dev_state == DV_NORMAL)
    else $error("precharge all timing wrong");
  a_rda_ends: assert property (cmd_valid && !cmd_illegal && cmd_code == CMD_RDA |->
    cur_bk == BK_AUTO_PRE ##[17:22] cur_bk == BK_IDLE)
    else $error("auto precharge timing wrong");
  a_sref_odt: assert property (dev_state == DV_SELF_REF |-> !odt_active)
    else $error("termination on in self refresh");
endmodule // dcb_chk
bind dcb_top dcb_chk u_chk (.clk_sys, .arst_n, .cmd_code, .cmd_valid, .cmd_illegal,
  .cmd_bank, .bank_states, .dev_state, .odt_active, .mode_reg_sel, .mode_load);
`default_nettype wire

// ===== testbench/dcb_ctl.sv
/* controller model: drives link clock and command pins
   assumes the bench calls issue and wake at most one at a time */
`timescale 1ns/1ns
`default_nettype none
module dcb_ctl
  import dcb_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // memory link pins
  output logic mem_ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [dcb_pkg::BA_W-1:0] ba,
  output logic [dcb_pkg::ADDR_W-1:0] addr
);
  // =========================================================
  // one command per link clock period, clock still between
  initial
  begin
    {mem_ck, cke, cs_n} = 3'h1;
    {ras_n, cas_n, we_n} = ENC_NOP;
    ba = '0;
    addr = '0;
  end
  task automatic issue(input logic k, input logic [2:0] e, input logic [2:0] b, input logic a);
    @(negedge clk_sys);
    cke = k;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = e;
    ba = b;
    // unused bits never hold still
    addr = {~addr[ADDR_W-1:AP_BIT+1], a, ~addr[AP_BIT-1:0]};
    @(negedge clk_sys);
    mem_ck = 1'b1;
    repeat (4) @(negedge clk_sys);
    mem_ck = 1'b0;
    repeat (3) @(negedge clk_sys);
    cs_n = 1'b1; // deselect between commands
    ba = ~ba;
  endtask
  task automatic wake;
    @(negedge clk_sys);
    cke = 1'b1; // exit with deselect, clock stopped
  endtask
endmodule // dcb_ctl
`default_nettype wire

// ===== testbench/dcb_top_bench.sv
/* self-checking bench for the command tracker
   assumes dcb_ctl as controller and the checker bound in */
`timescale 1ns/1ns
`default_nettype none
module dcb_top_bench;
  import dcb_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic odt = 1'b0;
  wire logic mem_ck, cke, cs_n, ras_n, cas_n, we_n;
  wire logic [2:0] ba;
  wire logic [13:0] addr;
  logic [3:0] cmd_code, cc;
  logic cmd_valid, cmd_illegal, odt_active, mode_load, cv, ci, ml;
  logic [2:0] cmd_bank, dev_state, mode_reg_sel, cd;
  logic [11:0] bank_states, cb;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // =========================================================
  // parts
  always #25 clk_sys = ~clk_sys;
  dcb_ctl p (.clk_sys, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
  dcb_top dut (.clk_sys, .arst_n, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .odt, .cmd_code, .cmd_valid, .cmd_illegal, .cmd_bank, .bank_states,
    .dev_state, .odt_active, .mode_reg_sel, .mode_load);
  // pulses last one cycle, so keep a copy
  always @(posedge clk_sys)
    if (cmd_valid || cmd_illegal)
    begin
      {cv, ci, ml, cc, cb, cd} <= {cmd_valid, cmd_illegal, mode_load, cmd_code,
        bank_states, dev_state};
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      results;
    end
  end
  // =========================================================
  // shared tasks
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] x);
    num_checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [2:0] bk(input logic [11:0] v, input int i);
    return v[3*i +: 3];
  endfunction
  task automatic run(input logic k, input logic [2:0] e, input logic [2:0] b, input logic a);
    {cv, ci, ml} = 3'h0;
    p.issue(k, e, b, a);
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // =========================================================
  // scenarios
  task automatic t_bank;
    chk("banks", bank_states, 12'h000);
    run(1, ENC_NOP, 0, 0); // enable high twice before real commands
    run(1, ENC_ACT, 3'h5, 0); // top bank bit beyond four banks
    chk("act valid", cv, 1);
    chk("act code", cc, CMD_ACT);
    chk("act bank", cmd_bank, 3'h5);
    chk("act mid", bk(cb, 1), BK_ACTIVATING);
    chk("act end", bk(bank_states, 1), BK_ACTIVE);
    run(1, ENC_RD, 1, 0);
    chk("rd code", cc, CMD_RD);
    chk("rd state", bk(cb, 1), BK_READ);
    run(1, ENC_WR, 1, 0); // write inside the read burst
    chk("wr refused", ci, 1);
    chk("rd kept", bk(bank_states, 1), BK_READ);
    gap(20); // burst of four runs out
    chk("rd end", bk(bank_states, 1), BK_ACTIVE);
    run(1, ENC_RD, 1, 1);
    chk("rda code", cc, CMD_RDA);
    chk("rda mid", bk(cb, 1), BK_AUTO_PRE);
    run(1, ENC_NOP, 1, 0); // only nop while auto precharge runs
    chk("rda busy", bk(bank_states, 1), BK_AUTO_PRE);
    gap(20);
    chk("rda end", bk(bank_states, 1), BK_IDLE);
    $display("bank access test done");
  endtask
  task automatic t_pre;
    run(1, ENC_ACT, 2, 0);
    run(1, ENC_WR, 2, 0);
    chk("wr state", bk(cb, 2), BK_WRITE);
    run(1, ENC_RD, 2, 0); // read taken inside the write burst
    chk("wr to rd", bk(cb, 2), BK_READ);
    run(1, ENC_PRE, 2, 0);
    chk("pre code", cc, CMD_PRE);
    chk("pre mid", bk(cb, 2), BK_PRECHARGING);
    chk("pre end", bk(bank_states, 2), BK_IDLE);
    run(1, ENC_ACT, 0, 0);
    run(1, ENC_PRE, 3, 1); // only active or idle banks in the group
    chk("prea code", cc, CMD_PREA);
    chk("prea mid", cd, DV_PRE_ALL);
    chk("prea end", bank_states, 12'h000);
    $display("precharge test done");
  endtask
  task automatic t_dev;
    run(1, ENC_ACT, 0, 0);
    run(1, ENC_REF, 0, 0); // refresh with a row open
    chk("ref refused", ci, 1);
    chk("ref kept", bk(bank_states, 0), BK_ACTIVE);
    run(1, ENC_PRE, 0, 0);
    run(1, ENC_REF, 0, 0);
    chk("ref mid", cd, DV_REFRESH);
    chk("ref end", dev_state, DV_NORMAL);
    run(1, ENC_LMR, 2, 0);
    chk("lmr pulse", ml, 1);
    chk("lmr mid", cd, DV_MODE);
    chk("lmr sel", mode_reg_sel, 2);
    chk("lmr end", dev_state, DV_NORMAL);
    run(0, ENC_NOP, 0, 0); // short stay, well inside the refresh interval
    chk("pdn", dev_state, DV_POWER_DN);
    run(1, ENC_NOP, 0, 0);
    chk("pdn exit", dev_state, DV_NORMAL);
    $display("device state test done");
  endtask
  task automatic t_sref;
    odt = 1'b1;
    gap(4);
    chk("odt on", odt_active, 1);
    run(0, ENC_REF, 0, 0);
    chk("sref", dev_state, DV_SELF_REF);
    chk("odt off", odt_active, 0);
    p.wake;
    repeat (8) if (dev_state === DV_SELF_REF) @(negedge clk_sys);
    chk("sref exit", dev_state, DV_EXIT_WAIT);
    gap(8);
    chk("sref end", dev_state, DV_NORMAL);
    odt = 1'b0;
    $display("self refresh test done");
  endtask
  // =========================================================
  // main sequence
  initial
  begin
    gap(5);
    arst_n = 1'b1;
    gap(3);
    t_bank;
    t_pre;
    t_dev;
    t_sref;
    results;
  end
endmodule // dcb_top_bench
`default_nettype wire
